// File: logic/ttsr_time_slot_router.sv
// Time slot assigner top: host settings, route memories, four engines, bus pins
`timescale 1ns/1ps
module ttsr_time_slot_router
  import ttsr_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic                tx_mem_we_i,
  input  wire logic                rx_mem_we_i,
  input  wire logic [AW-1:0]       mem_addr_i,
  input  wire logic [DW-1:0]       mem_wdata_i,
  output logic      [DW-1:0]       tx_mem_rdata_o,
  output logic      [DW-1:0]       rx_mem_rdata_o,
  input  wire logic [1:0]          route_memory_division_i,
  input  wire logic [1:0]          bus_interface_enable_i,
  input  wire logic [3:0]          serial_channel_connect_i,
  input  wire logic [1:0]          mgmt_channel_connect_i,
  input  wire logic [1:0]          common_timing_i,
  input  wire logic [1:0]          echo_mode_i,
  input  wire logic [1:0]          loopback_mode_i,
  input  wire logic [1:0]          shadow_swap_set_i,
  output logic      [1:0]          shadow_swap_request_o,
  output logic      [1:0]          current_half_o,
  input  wire logic                serial_timing_clk_i,
  input  wire logic [1:0]          tdm_rx_sync_i,
  input  wire logic [1:0]          tdm_rx_clk_i,
  input  wire logic [1:0]          tdm_tx_sync_i,
  input  wire logic [1:0]          tdm_tx_clk_i,
  input  wire logic [1:0]          tdm_rxd_i,
  output logic      [1:0]          tdm_txd_o,
  output logic      [1:0]          tdm_txd_oe_o,
  output logic      [NUM_STB-1:0]  strobe_o,
  output logic      [NUM_CHAN-1:0] chan_rx_data_o,
  output logic      [NUM_CHAN-1:0] chan_rx_valid_o,
  input  wire logic [NUM_CHAN-1:0] chan_tx_data_i,
  output logic      [NUM_CHAN-1:0] chan_tx_take_o,
  output logic      [3:0]          frame_error_o
);
  // Host domain state
  logic [1:0] swap_req_ff, nxt_swap_req;  // Pending swap requests
  logic [1:0] done_s1_ff, done_s2_ff;     // Swap done toggle sync
  logic [1:0] done_prev_ff;               // Last seen done toggle
  logic [1:0] half_s1_ff, half_s2_ff;     // Current half sync
  // Link domain state
  logic       lrst_s1_ff, lrst_n_ff;      // Link reset release sync
  ttsr_cfg_t  cfg_in, cfg_s1_ff, cfg;     // Settings crossing
  ttsr_pins_t pins_in, pin_s1_ff, pin;    // Pin synchronisers
  logic [3:0] clkp_ff, clk_line;          // Clock lines and history
  logic [3:0] tick, sync_line;            // Per engine bit tick, sync
  logic [1:0] half_ff, nxt_half;          // Current half per bus
  logic [1:0] wait_ff, nxt_wait;          // Swapped, request not yet gone
  logic [1:0] tgl_ff, nxt_tgl;            // Swap done toggle
  logic [1:0][AW-1:0] base;               // Frame base per bus
  logic [AW-1:0]      mask;               // Partition mask
  logic [3:0][AW-1:0] eng_addr;           // Engine word address
  logic [3:0][DW-1:0] eng_word;           // Engine route word
  logic [3:0]         eng_frame;          // Engine frame start
  logic [3:0]         eng_bit;            // Engine bit pulse
  logic [3:0][2:0]    eng_channel_select_field;           // Engine channel code
  logic [3:0][3:0]    eng_stb;            // Engine strobes
  logic [3:0]         eng_halt;           // Engine halted
  logic [NUM_CHAN-1:0] conn;              // Connect bits, channel order
  logic [NUM_CHAN-1:0] rxd_ff, nxt_rxd;   // Channel receive data
  logic [NUM_CHAN-1:0] rxv_ff, nxt_rxv;   // Channel receive strobe
  logic [NUM_CHAN-1:0] take_ff, nxt_take; // Channel transmit take
  logic [1:0]          txd_ff, nxt_txd;   // Transmit pin data
  logic [1:0]          oe_ff, nxt_oe;     // Transmit pin enable
  logic [NUM_STB-1:0]  stb_ff, nxt_stb;   // Strobe pins
  logic [3:0]          err_ff;            // Halt status

  // Swap request: set by host, cleared on done toggle, set wins
  always_comb begin
    nxt_swap_req = (swap_req_ff & ~(done_s2_ff ^ done_prev_ff)) | shadow_swap_set_i;
  end

  // Host domain registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      swap_req_ff  <= 2'h0;
      done_s1_ff   <= 2'h0;
      done_s2_ff   <= 2'h0;
      done_prev_ff <= 2'h0;
      half_s1_ff   <= 2'h0;
      half_s2_ff   <= 2'h0;
    end else begin
      swap_req_ff  <= nxt_swap_req;
      done_s1_ff   <= tgl_ff;
      done_s2_ff   <= done_s1_ff;
      done_prev_ff <= done_s2_ff;
      half_s1_ff   <= half_ff;
      half_s2_ff   <= half_s1_ff;
    end
  end

  assign shadow_swap_request_o = swap_req_ff;
  assign current_half_o        = half_s2_ff;

  // Link reset: asserted at once, released on the link clock
  always_ff @(posedge serial_timing_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lrst_s1_ff <= 1'b0;
      lrst_n_ff  <= 1'b0;
    end else begin
      lrst_s1_ff <= 1'b1;
      lrst_n_ff  <= lrst_s1_ff;
    end
  end

  // Gather settings and pins for the crossing
  always_comb begin
    cfg_in             = '0;
    cfg_in.swap_req    = swap_req_ff;
    cfg_in.common      = common_timing_i;
    cfg_in.loop        = loopback_mode_i;
    cfg_in.echo        = echo_mode_i;
    cfg_in.mgmt_conn   = mgmt_channel_connect_i;
    cfg_in.serial_conn = serial_channel_connect_i;
    cfg_in.enable      = bus_interface_enable_i;
    cfg_in.division    = route_memory_division_i;
    pins_in            = {tdm_rxd_i, tdm_tx_clk_i, tdm_tx_sync_i, tdm_rx_clk_i, tdm_rx_sync_i};
  end

  // Two-stage synchronisers and clock line history
  always_ff @(posedge serial_timing_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      cfg_s1_ff <= '0;
      cfg       <= '0;
      pin_s1_ff <= '0;
      pin       <= '0;
      clkp_ff   <= 4'h0;
    end else begin
      cfg_s1_ff <= cfg_in;
      cfg       <= cfg_s1_ff;
      pin_s1_ff <= pins_in;
      pin       <= pin_s1_ff;
      clkp_ff   <= clk_line;
    end
  end

  // Bit ticks on rising serial clock, shared or split timing
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      clk_line[2*b]    = pin.rx_clk[b];
      sync_line[2*b]   = pin.rx_sync[b];
      clk_line[2*b+1]  = cfg.common[b] ? pin.rx_clk[b] : pin.tx_clk[b];
      sync_line[2*b+1] = cfg.common[b] ? pin.rx_sync[b] : pin.tx_sync[b];
    end
    tick = clk_line & ~clkp_ff;
  end

  // Partition size and swap of current and shadow halves
  always_comb begin
    nxt_half = half_ff;
    nxt_wait = wait_ff;
    nxt_tgl  = tgl_ff;
    case (cfg.division)
      2'h0: mask = MASK_64;
      2'h1: mask = MASK_32;
      2'h2: mask = MASK_32;
      default: mask = MASK_16;
    endcase
    for (int b = 0; b < 2; b++) begin
      if (!cfg.swap_req[b]) begin
        nxt_wait[b] = 1'b0;
      end else if (cfg.division[MODE_DYN_BIT] && cfg.enable[b] && !wait_ff[b]
                   && (eng_frame[2*b] || eng_frame[2*b+1])) begin
        nxt_half[b] = ~half_ff[b];
        nxt_wait[b] = 1'b1;
        nxt_tgl[b]  = ~tgl_ff[b];
      end
      base[b] = '0;
      if (cfg.division[MODE_TWO_BIT] && b == 1) begin
        base[b] = BASE_BUS_B;
      end
      if (cfg.division[MODE_DYN_BIT] && nxt_half[b]) begin
        base[b] = base[b] | (cfg.division[MODE_TWO_BIT] ? HALF_TWO : HALF_ONE);
      end
    end
  end

  // Receive route memory, engines 0 and 2
  ttsr_route_mem u_rx_mem (
    .host_clk_i     (clk_i),
    .host_reset_n_i (reset_n_i),
    .we_i           (rx_mem_we_i),
    .addr_i         (mem_addr_i),
    .wdata_i        (mem_wdata_i),
    .rdata_o        (rx_mem_rdata_o),
    .lnk_clk_i      (serial_timing_clk_i),
    .lnk_reset_n_i  (lrst_n_ff),
    .raddr_a_i      (eng_addr[0]),
    .raddr_b_i      (eng_addr[2]),
    .rdata_a_o      (eng_word[0]),
    .rdata_b_o      (eng_word[2])
  );

  // Transmit route memory, engines 1 and 3
  ttsr_route_mem u_tx_mem (
    .host_clk_i     (clk_i),
    .host_reset_n_i (reset_n_i),
    .we_i           (tx_mem_we_i),
    .addr_i         (mem_addr_i),
    .wdata_i        (mem_wdata_i),
    .rdata_o        (tx_mem_rdata_o),
    .lnk_clk_i      (serial_timing_clk_i),
    .lnk_reset_n_i  (lrst_n_ff),
    .raddr_a_i      (eng_addr[1]),
    .raddr_b_i      (eng_addr[3]),
    .rdata_a_o      (eng_word[1]),
    .rdata_b_o      (eng_word[3])
  );

  // One engine per bus and direction
  for (genvar e = 0; e < 4; e++) begin : g_eng
    ttsr_route_engine u_eng (
      .clk_i     (serial_timing_clk_i),
      .reset_n_i (lrst_n_ff),
      .tick_i    (tick[e]),
      .sync_i    (sync_line[e]),
      .en_i      (cfg.enable[e/2]),
      .base_i    (base[e/2]),
      .mask_i    (mask),
      .word_i    (eng_word[e]),
      .addr_o    (eng_addr[e]),
      .frame_o   (eng_frame[e]),
      .bit_o     (eng_bit[e]),
      .channel_select_field_o    (eng_channel_select_field[e]),
      .strobe_o  (eng_stb[e]),
      .halt_o    (eng_halt[e])
    );
  end

  // Routing of bits between pins and channels
  always_comb begin
    conn     = {cfg.mgmt_conn, cfg.serial_conn};
    nxt_rxd  = rxd_ff;
    nxt_rxv  = '0;
    nxt_take = '0;
    nxt_txd  = txd_ff;
    nxt_oe   = oe_ff;
    nxt_stb  = '0;
    for (int b = 1; b >= 0; b--) begin
      // Transmit pin
      if (!cfg.enable[b]) begin
        nxt_oe[b] = 1'b0;
      end else if (cfg.echo[b]) begin
        nxt_txd[b] = pin.rxd[b];
        nxt_oe[b]  = 1'b1;
      end else if (eng_bit[2*b+1]) begin
        if (eng_channel_select_field[2*b+1] != CHANNEL_SELECT_FIELD_NONE_LO && eng_channel_select_field[2*b+1] != CHANNEL_SELECT_FIELD_NONE_HI
            && conn[eng_channel_select_field[2*b+1]-3'h1]) begin
          nxt_txd[b] = chan_tx_data_i[eng_channel_select_field[2*b+1]-3'h1];
          nxt_oe[b]  = 1'b1;
          nxt_take[eng_channel_select_field[2*b+1]-3'h1] = 1'b1;
        end else begin
          nxt_oe[b] = 1'b0;
        end
      end
      // Receive: bus 0 wins on a shared channel; loopback takes this bit's transmit value
      if (eng_bit[2*b] && cfg.enable[b] && eng_channel_select_field[2*b] != CHANNEL_SELECT_FIELD_NONE_LO
          && eng_channel_select_field[2*b] != CHANNEL_SELECT_FIELD_NONE_HI && conn[eng_channel_select_field[2*b]-3'h1]) begin
        nxt_rxd[eng_channel_select_field[2*b]-3'h1] = cfg.loop[b] ? nxt_txd[b] : pin.rxd[b];
        nxt_rxv[eng_channel_select_field[2*b]-3'h1] = 1'b1;
      end
    end
    // Strobes are the OR of every engine
    for (int e = 0; e < 4; e++) begin
      nxt_stb = nxt_stb | eng_stb[e];
    end
  end

  // Link domain output and swap registers
  always_ff @(posedge serial_timing_clk_i or negedge lrst_n_ff) begin
    if (!lrst_n_ff) begin
      half_ff <= 2'h0;
      wait_ff <= 2'h0;
      tgl_ff  <= 2'h0;
      rxd_ff  <= '0;
      rxv_ff  <= '0;
      take_ff <= '0;
      txd_ff  <= 2'h0;
      oe_ff   <= 2'h0;
      stb_ff  <= '0;
      err_ff  <= 4'h0;
    end else begin
      half_ff <= nxt_half;
      wait_ff <= nxt_wait;
      tgl_ff  <= nxt_tgl;
      rxd_ff  <= nxt_rxd;
      rxv_ff  <= nxt_rxv;
      take_ff <= nxt_take;
      txd_ff  <= nxt_txd;
      oe_ff   <= nxt_oe;
      stb_ff  <= nxt_stb;
      err_ff  <= eng_halt;
    end
  end

  assign tdm_txd_o       = txd_ff;
  assign tdm_txd_oe_o    = oe_ff;
  assign strobe_o        = stb_ff;
  assign chan_rx_data_o  = rxd_ff;
  assign chan_rx_valid_o = rxv_ff;
  assign chan_tx_take_o  = take_ff;
  assign frame_error_o   = err_ff;
endmodule

// File: logic/ttsr_pkg.sv
// Shared constants and types of the time slot router
package ttsr_pkg;
  // Route memory geometry
  localparam int MEM_DEPTH = 64;
  localparam int AW        = 6;
  localparam int DW        = 16;
  localparam int NUM_CHAN  = 6;
  localparam int NUM_STB   = 4;
  // Route word field positions
  localparam int W_LST     = 0;
  localparam int W_BYT     = 1;
  localparam int W_CNT_LO  = 2;
  localparam int W_CHANNEL_SELECT_FIELD_LO = 6;
  localparam int W_SSEL_LO = 10;
  // Channel select codes that route nowhere
  localparam logic [2:0] CHANNEL_SELECT_FIELD_NONE_LO = 3'h0;
  localparam logic [2:0] CHANNEL_SELECT_FIELD_NONE_HI = 3'h7;
  // Longest frame, last bit index
  localparam logic [12:0] FRAME_LAST_BIT = 13'h1FFF;
  // Division mode bit positions
  localparam int MODE_DYN_BIT = 0;
  localparam int MODE_TWO_BIT = 1;
  // Partition masks and offsets
  localparam logic [5:0] MASK_64    = 6'h3F;
  localparam logic [5:0] MASK_32    = 6'h1F;
  localparam logic [5:0] MASK_16    = 6'h0F;
  localparam logic [5:0] BASE_BUS_B = 6'h20;
  localparam logic [5:0] HALF_ONE   = 6'h20;
  localparam logic [5:0] HALF_TWO   = 6'h10;
  // Engine states
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} ttsr_state_t;
  // Software settings carried into the link domain
  typedef struct packed {
    logic [1:0] swap_req;
    logic [1:0] common;
    logic [1:0] loop;
    logic [1:0] echo;
    logic [1:0] mgmt_conn;
    logic [3:0] serial_conn;
    logic [1:0] enable;
    logic [1:0] division;
  } ttsr_cfg_t;
  // Bus pins, one bit per bus
  typedef struct packed {
    logic [1:0] rxd;
    logic [1:0] tx_clk;
    logic [1:0] tx_sync;
    logic [1:0] rx_clk;
    logic [1:0] rx_sync;
  } ttsr_pins_t;
endpackage

// File: logic/ttsr_route_mem.sv
// One 64x16 route memory: host write/read port, two link read ports
`timescale 1ns/1ps
module ttsr_route_mem
  import ttsr_pkg::*;
(
  input  wire logic          host_clk_i,
  input  wire logic          host_reset_n_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          lnk_clk_i,
  input  wire logic          lnk_reset_n_i,
  input  wire logic [AW-1:0] raddr_a_i,
  input  wire logic [AW-1:0] raddr_b_i,
  output logic      [DW-1:0] rdata_a_o,
  output logic      [DW-1:0] rdata_b_o
);
  // Storage, not cleared at reset
  logic [DW-1:0] mem [MEM_DEPTH];

  // Registered host read
  always_ff @(posedge host_clk_i or negedge host_reset_n_i) begin
    if (!host_reset_n_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem[addr_i];
    end
  end

  // Write port without reset: contents undefined at power-on
  always_ff @(posedge host_clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  // Registered link reads, one per bus
  always_ff @(posedge lnk_clk_i or negedge lnk_reset_n_i) begin
    if (!lnk_reset_n_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule

// File: logic/ttsr_route_engine.sv
// Route word sequencer for one bus and one direction
`timescale 1ns/1ps
module ttsr_route_engine
  import ttsr_pkg::*;
(
  input  wire logic          clk_i,
  input  wire logic          reset_n_i,
  input  wire logic          tick_i,
  input  wire logic          sync_i,
  input  wire logic          en_i,
  input  wire logic [AW-1:0] base_i,
  input  wire logic [AW-1:0] mask_i,
  input  wire logic [DW-1:0] word_i,
  output logic      [AW-1:0] addr_o,
  output logic               frame_o,
  output logic               bit_o,
  output logic      [2:0]    channel_select_field_o,
  output logic      [3:0]    strobe_o,
  output logic               halt_o
);
  ttsr_state_t state_ff, nxt_state;      // Sequencer state
  logic [AW-1:0] ptr_ff, nxt_ptr;         // Word offset in partition
  logic [AW-1:0] base_ff, nxt_base;       // Partition base of frame
  logic [7:0]    ucnt_ff, nxt_ucnt;       // Bit within group
  logic [12:0]   fcnt_ff, nxt_fcnt;       // Bit within frame
  logic          sprev_ff, nxt_sprev;     // Sync at previous tick
  logic          bit_ff, nxt_bit;         // Bit time pulse
  logic [2:0]    channel_select_field_ff, nxt_channel_select_field;       // Channel of this bit
  logic [3:0]    stb_ff, nxt_stb;         // Strobe levels
  logic [4:0]    units;                   // Units in group
  logic [7:0]    glast;                   // Last bit index of group

  // Frame start: sync rising as seen at clock ticks
  assign frame_o  = tick_i & sync_i & ~sprev_ff & en_i;
  assign units    = {1'b0, word_i[W_CNT_LO +: 4]} + 5'h01;
  assign glast    = word_i[W_BYT] ? {units, 3'h0} - 8'h01 : {3'h0, units} - 8'h01;
  assign addr_o   = base_ff | (ptr_ff & mask_i);
  assign bit_o    = bit_ff;
  assign channel_select_field_o   = channel_select_field_ff;
  assign strobe_o = stb_ff;
  assign halt_o   = (state_ff == ST_HALT);

  // Next state of the sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_ptr   = ptr_ff;
    nxt_base  = base_ff;
    nxt_ucnt  = ucnt_ff;
    nxt_fcnt  = fcnt_ff;
    nxt_sprev = tick_i ? sync_i : sprev_ff;
    nxt_bit   = 1'b0;
    nxt_channel_select_field  = channel_select_field_ff;
    nxt_stb   = stb_ff;
    if (!en_i) begin
      // Disabled bus is not processed
      nxt_state = ST_IDLE;
      nxt_stb   = 4'h0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // Strobes drop once the last entry is done
          if (tick_i) begin
            nxt_stb = 4'h0;
          end
          if (frame_o) begin
            nxt_state = ST_RUN;
            nxt_ptr   = '0;
            nxt_ucnt  = 8'h00;
            nxt_fcnt  = 13'h0000;
            nxt_base  = base_i;
          end
        end
        ST_RUN: begin
          if (frame_o) begin
            // Early sync: stop until another sync
            nxt_state = ST_HALT;
            nxt_stb   = 4'h0;
          end else if (tick_i) begin
            nxt_bit  = 1'b1;
            nxt_channel_select_field = word_i[W_CHANNEL_SELECT_FIELD_LO +: 3];
            nxt_stb  = word_i[W_SSEL_LO +: 4];
            nxt_fcnt = fcnt_ff + 13'h0001;
            nxt_ucnt = ucnt_ff + 8'h01;
            if (ucnt_ff == glast) begin
              nxt_ucnt = 8'h00;
              nxt_ptr  = ptr_ff + 6'h01;
            end
            // Last word or longest frame ends the frame
            if ((ucnt_ff == glast && word_i[W_LST]) || fcnt_ff == FRAME_LAST_BIT) begin
              nxt_state = ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          // Third sync restarts from the first word
          if (frame_o) begin
            nxt_state = ST_RUN;
            nxt_ptr   = '0;
            nxt_ucnt  = 8'h00;
            nxt_fcnt  = 13'h0000;
            nxt_base  = base_i;
          end
        end
        default: begin
          nxt_state = ST_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= ST_IDLE;
      ptr_ff   <= '0;
      base_ff  <= '0;
      ucnt_ff  <= 8'h00;
      fcnt_ff  <= 13'h0000;
      sprev_ff <= 1'b0;
      bit_ff   <= 1'b0;
      channel_select_field_ff  <= 3'h0;
      stb_ff   <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      ptr_ff   <= nxt_ptr;
      base_ff  <= nxt_base;
      ucnt_ff  <= nxt_ucnt;
      fcnt_ff  <= nxt_fcnt;
      sprev_ff <= nxt_sprev;
      bit_ff   <= nxt_bit;
      channel_select_field_ff  <= nxt_channel_select_field;
      stb_ff   <= nxt_stb;
    end
  end
endmodule

// File: verif/ttsr_props.sv
// Port checks of the time slot router
`timescale 1ns/1ps
module ttsr_props
  import ttsr_pkg::*;
(
  input wire logic [0:0]      clk_i,
  input wire logic [0:0]      reset_n_i,
  input wire logic [0:0]      tx_mem_we_i,
  input wire logic [0:0]      rx_mem_we_i,
  input wire logic [AW-1:0]   mem_addr_i,
  input wire logic [DW-1:0]   mem_wdata_i,
  input wire logic [DW-1:0]   tx_mem_rdata_o,
  input wire logic [DW-1:0]   rx_mem_rdata_o,
  input wire logic [1:0]      route_memory_division_i,
  input wire logic [1:0]      bus_interface_enable_i,
  input wire logic [3:0]      serial_channel_connect_i,
  input wire logic [1:0]      mgmt_channel_connect_i,
  input wire logic [1:0]      shadow_swap_set_i,
  input wire logic [1:0]      shadow_swap_request_o,
  input wire logic [1:0]      current_half_o,
  input wire logic [0:0]      serial_timing_clk_i,
  input wire logic [3:0]      strobe_o,
  input wire logic [5:0]      chan_rx_valid_o,
  input wire logic [3:0]      frame_error_o
);
  tx_read_back_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    tx_mem_we_i ##1 $stable(mem_addr_i) |=> tx_mem_rdata_o == $past(mem_wdata_i, 2)) else $error("tx word lost");
  rx_read_back_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rx_mem_we_i ##1 $stable(mem_addr_i) |=> rx_mem_rdata_o == $past(mem_wdata_i, 2)) else $error("rx word lost");
  swap_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    shadow_swap_set_i[0] |=> shadow_swap_request_o[0]) else $error("swap request not set");
  swap_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    shadow_swap_request_o[0] && !route_memory_division_i[0] |=> shadow_swap_request_o[0]) else $error("swap dropped");
  swap_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $changed(current_half_o[0]) |-> ##[0:16] !shadow_swap_request_o[0]) else $error("swap not cleared");
  idle_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    bus_interface_enable_i == 2'h0 [*8] |=> strobe_o == 4'h0) else $error("strobe while disabled");
  rx_conn_a: assert property (@(posedge serial_timing_clk_i) disable iff (!reset_n_i)
    (chan_rx_valid_o & ~{mgmt_channel_connect_i, serial_channel_connect_i}) == 6'h00) else $error("unconnected rx");
  halt_quiet_a: assert property (@(posedge serial_timing_clk_i) disable iff (!reset_n_i)
    $past(frame_error_o[0]) && frame_error_o[0] |-> chan_rx_valid_o == 6'h00) else $error("rx while halted");
  cover property (@(posedge clk_i) disable iff (!reset_n_i) $fell(shadow_swap_request_o[0]));
  cover property (@(posedge clk_i) disable iff (!reset_n_i) $rose(frame_error_o[0]));
  cover property (@(posedge clk_i) disable iff (!reset_n_i) strobe_o != 4'h0);
endmodule
bind ttsr_time_slot_router ttsr_props u_props (.*);

// File: verif/ttsr_tdm_partner.sv
// TDM bus partner: frame sync, bit clock and receive data per bus
`timescale 1ns/1ps
module ttsr_tdm_partner (
  output logic [1:0] sync_o,
  output logic [1:0] clk_o,
  output logic [1:0] rxd_o
);
  // Clock stands low between frames
  initial begin
    sync_o = 2'h0;
    clk_o  = 2'h0;
    rxd_o  = 2'h0;
  end
  // One bit time of 100 ns, slower than link clock over 2.5
  task automatic tick(input int b, input logic s, input logic d);
    sync_o[b] = s;
    rxd_o[b]  = d;
    #40 clk_o[b] = 1'b1;
    #60 clk_o[b] = 1'b0;
  endtask
  // Released line shows the inverse of its last bit
  task automatic idle(input int b);
    rxd_o[b] = ~rxd_o[b];
  endtask
endmodule

// File: verif/tb_top.sv
// Bench: route model with channel queues compared against the router
`timescale 1ns/1ps
module tb_top;
  import ttsr_pkg::*;
  localparam logic [5:0] CONN = 6'h2B;
  logic          clk_i, reset_n_i, tx_mem_we_i, rx_mem_we_i, serial_timing_clk_i;
  logic [AW-1:0] mem_addr_i;
  logic [DW-1:0] mem_wdata_i, tx_mem_rdata_o, rx_mem_rdata_o, mem [64];
  logic [1:0]    route_memory_division_i, bus_interface_enable_i, echo_mode_i, shadow_swap_set_i;
  logic [1:0]    mgmt_channel_connect_i, common_timing_i, loopback_mode_i, shadow_swap_request_o;
  logic [1:0]    current_half_o, tdm_rx_sync_i, tdm_rx_clk_i, tdm_tx_sync_i, tdm_tx_clk_i, tdm_rxd_i;
  logic [1:0]    tdm_txd_o, tdm_txd_oe_o;
  logic [3:0]    serial_channel_connect_i, strobe_o, frame_error_o;
  logic [5:0]    chan_rx_data_o, chan_rx_valid_o, chan_tx_data_i, chan_tx_take_o;
  logic          q_e [6][$], q_g [6][$];
  logic [31:0]   lf = 32'h00011CF1;
  logic [1:0]    om = 2'h0;
  int            n_fail, n_tests, hb [2], nt_g, nt_e;
  ttsr_time_slot_router dut (.*);
  ttsr_tdm_partner p (.sync_o(tdm_rx_sync_i), .clk_o(tdm_rx_clk_i), .rxd_o(tdm_rxd_i));
  assign tdm_tx_sync_i = tdm_rx_sync_i;
  assign tdm_tx_clk_i  = tdm_rx_clk_i;
  // Clocks, link clock 12 ns with its own phase
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    serial_timing_clk_i = 1'b0;
    #1;
    forever #6 serial_timing_clk_i = ~serial_timing_clk_i;
  end
  // Collect routed receive bits and transmit takes
  always @(posedge serial_timing_clk_i) begin
    for (int k = 0; k < 6; k++) begin
      if (chan_rx_valid_o[k] === 1'b1) q_g[k].push_back(chan_rx_data_o[k]);
      if (chan_tx_take_o[k] === 1'b1) nt_g++;
    end
  end
  function automatic logic [31:0] rnd();
    lf = lf[0] ? (lf >> 1) ^ 32'hA3000000 : lf >> 1;
    return lf;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    $display("mismatches %0d of %0d", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Word to both memories, read back a cycle after the write edge
  task automatic wr(input int a, input logic [15:0] w);
    @(posedge clk_i);
    {tx_mem_we_i, rx_mem_we_i} <= 2'h3;
    mem_addr_i  <= a[5:0];
    mem_wdata_i <= w;
    mem[a] = w;
    @(posedge clk_i);
    {tx_mem_we_i, rx_mem_we_i} <= 2'h0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(tx_mem_rdata_o, w);
    chk(rx_mem_rdata_o, w);
  endtask
  // Four random words, last flag on the fourth
  task automatic prog(input int b);
    logic [31:0] r;
    for (int k = 0; k < 4; k++) begin
      r = rnd();
      wr(b + k, {2'h0, r[3:0], 1'b0, r[6:4], 2'h0, r[8:7], r[9], k == 3});
    end
  endtask
  function automatic int len(input logic [15:0] w);
    return (w[5:2] + 1) * (w[1] ? 8 : 1);
  endfunction
  // One frame of 140 bits; err adds a sync at bit 2, inside the shortest frame
  task automatic frame(input int b, input bit err, input bit on);
    int a, left, c;
    logic [15:0] w;
    logic [31:0] r;
    logic d, run, ok;
    repeat (4) @(posedge clk_i);
    r = rnd();
    chan_tx_data_i <= r[5:0];
    if (route_memory_division_i[0] && bus_interface_enable_i[b] && shadow_swap_request_o[b]) hb[b] ^= 1;
    a = b * 32 + (route_memory_division_i[0] ? hb[b] * (route_memory_division_i[1] ? 16 : 32) : 0);
    run = bus_interface_enable_i[b];
    w = mem[a];
    left = len(w);
    p.tick(b, 1'b1, 1'b0);
    for (int i = 0; i < 140; i++) begin
      r = rnd();
      d = r[0];
      if (err && i == 2) run = 1'b0;
      p.tick(b, err && i == 2, d);
      c = w[8:6];
      ok = c > 0 && c < 7 && CONN[c-1];
      if (run && ok) q_e[c-1].push_back(loopback_mode_i[b] ? chan_tx_data_i[c-1] : d);
      if (run || !bus_interface_enable_i[b]) om[b] = run && ok;
      if (on) begin
        chk(strobe_o, run ? w[13:10] : 4'h0);
        if (echo_mode_i[b]) chk(tdm_txd_o[b], d);
        else chk(tdm_txd_oe_o[b], om[b]);
        if (!echo_mode_i[b] && run && ok) begin
          chk(tdm_txd_o[b], chan_tx_data_i[c-1]);
          nt_e++;
        end
      end
      if (run) left--;
      if (run && left == 0 && w[0]) run = 1'b0;
      if (run && left == 0) begin
        a++;
        w = mem[a];
        left = len(w);
      end
    end
    p.idle(b);
    repeat (6) @(posedge serial_timing_clk_i);
    if (on) chk(16'(nt_g), 16'(nt_e));
    nt_g = 0;
    nt_e = 0;
    for (int k = 0; k < 6; k++) begin
      if (on) chk(16'(q_g[k].size()), 16'(q_e[k].size()));
      while (on && q_g[k].size() > 0 && q_e[k].size() > 0) chk(q_g[k].pop_front(), q_e[k].pop_front());
      q_g[k].delete();
      q_e[k].delete();
    end
    if (err) chk(frame_error_o, 16'(3 << (b * 2)));
  endtask
  initial begin
    #500000;
    n_fail++;
    complete_run();
  end
  initial begin
    {reset_n_i, tx_mem_we_i, rx_mem_we_i, mem_addr_i, mem_wdata_i, chan_tx_data_i} = '0;
    {route_memory_division_i, bus_interface_enable_i, echo_mode_i, shadow_swap_set_i} = '0;
    {loopback_mode_i, common_timing_i, mgmt_channel_connect_i, serial_channel_connect_i} = {2'h0, 2'h1, CONN};
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    prog(0);
    bus_interface_enable_i <= 2'h1;
    frame(0, 0, 1);
    frame(0, 1, 1);
    frame(0, 0, 1);
    @(posedge clk_i);
    bus_interface_enable_i <= 2'h0;
    frame(0, 0, 1);
    @(posedge clk_i);
    {route_memory_division_i, bus_interface_enable_i} <= 4'h5;
    prog(32);
    @(posedge clk_i);
    shadow_swap_set_i <= 2'h1;
    @(posedge clk_i);
    shadow_swap_set_i <= 2'h0;
    frame(0, 0, 0);
    frame(0, 0, 1);
    chk(shadow_swap_request_o, 2'h0);
    chk(current_half_o, 2'h1);
    @(posedge clk_i);
    {route_memory_division_i, bus_interface_enable_i} <= 4'hA;
    prog(32);
    frame(1, 0, 1);
    @(posedge clk_i);
    route_memory_division_i <= 2'h3;
    loopback_mode_i <= 2'h2;
    frame(1, 0, 1);
    @(posedge clk_i);
    {route_memory_division_i, bus_interface_enable_i, echo_mode_i} <= 6'h05;
    shadow_swap_set_i <= 2'h1;
    @(posedge clk_i);
    shadow_swap_set_i <= 2'h0;
    frame(0, 0, 1);
    chk(shadow_swap_request_o, 2'h1);
    complete_run();
  end
endmodule
